// file: pixel_output_port.sv
// Pixel output port of a triple video digitizer: pixel buses, word clock, syncs,
// crystal clock buffer, reset pin and serial address match.
// Assumes pixels, their line sync and the crystal tick come from logic on clock.
// How it works
// - Reset pin low 1 us reinitialises the device
// - Crystal clock out at full or half rate
// - Serial address 0x4C or 0x4D from select pin
// - Serial data open drain, only pulled low
// - Six 8-bit pixel buses, can float
// - Word clock: pixel rate, half in 48-bit mode
// - Second word clock always the complement
// - Line sync output aligned with pixel data
// - Aligned line sync carries no composite content
// - Frame sync rises 8 pixels after the line sync trailing edge
// - Buffered line sync passes source unchanged
// - Buffered frame sync covers composite disruption
`timescale 1ns/10ps

module pixel_output_port
   import port_consts::*;
(
   input  wire logic             clock,                  // System clock, 125 MHz
   input  wire logic             sys_rst,                // Synchronous reset, active high
   input  wire logic             clk_en,                 // Freezes all state while low
   input  wire logic             reset_pin_n,            // External reset pin, active low
   input  wire logic             crystal_tick,           // One pulse per crystal period
   input  wire logic             crystal_half_sel,       // 1: crystal clock out at half rate
   output logic                  crystal_clock_out,      // Buffered crystal clock
   input  wire logic             bus_address_select,     // Serial address strap pin
   input  wire logic             serial_clock,           // Serial clock pin from host
   input  wire logic             serial_data_in,         // Serial data pin level
   output logic                  serial_data_out,        // Serial data drive value
   output logic                  serial_data_oe_n,       // Low while pulling data low
   input  wire logic [PIX_W-1:0] pix_red,                // Red sample
   input  wire logic [PIX_W-1:0] pix_green,              // Green sample
   input  wire logic [PIX_W-1:0] pix_blue,               // Blue sample
   input  wire logic             pix_valid,              // One pulse per pixel clock
   input  wire logic             pix_line_sync,          // Line sync aligned with samples
   input  wire logic             mode_48,                // 1: 48-bit output mode
   input  wire logic             bus_disable,            // 1: float the pixel buses
   input  wire logic             hsync_pin,              // Line sync or composite pin
   input  wire logic             sog_pin,                // Sync-on-green pin
   input  wire logic             vsync_pin,              // Frame sync pin
   input  wire logic [1:0]       sync_source_sel,        // Line sync source
   output logic [PIX_W-1:0]      red_primary_bus,        // Red primary pixels
   output logic [PIX_W-1:0]      red_secondary_bus,      // Red secondary pixels
   output logic [PIX_W-1:0]      green_primary_bus,      // Green primary pixels
   output logic [PIX_W-1:0]      green_secondary_bus,    // Green secondary pixels
   output logic [PIX_W-1:0]      blue_primary_bus,       // Blue primary pixels
   output logic [PIX_W-1:0]      blue_secondary_bus,     // Blue secondary pixels
   output logic                  bus_oe_n,               // Low while buses are driven
   output logic                  output_word_clock,      // Data clock
   output logic                  output_word_clock_n,    // Inverse data clock
   output logic                  aligned_line_sync,      // Line sync aligned with data
   output logic                  synthetic_frame_sync,   // Frame sync aligned with data
   output logic                  line_sync_passthrough,  // Buffered line sync
   output logic                  frame_sync_passthrough  // Buffered frame sync
);
   typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_ACK, SER_SKIP} ser_state_e;

   logic                 rst_meta_reg, rst_sync_reg, ext_rst_reg, rst_int;
   logic [RST_CNT_W-1:0] rst_cnt_reg;
   logic                 xtal_phase_reg;
   logic [2:0]           ser_meta_reg, ser_sync_reg;
   logic                 scl_prev_reg, sda_prev_reg;
   logic                 ser_start, ser_stop, ser_rise, ser_fall;
   ser_state_e           ser_state_reg;
   logic [7:0]           ser_shift_reg;
   logic [3:0]           ser_cnt_reg;
   logic [6:0]           my_addr;
   logic                 phase_reg, launch;
   logic [PIX_W-1:0]     hold_r_reg, hold_g_reg, hold_b_reg;
   logic                 hs_prev_reg, hs_lead, hs_trail;
   logic [7:0]           hs_cnt_reg;
   logic                 disrupt, fs_prev_reg, frame_pend_reg;
   logic [3:0]           vs_cnt_reg;

   // Reset pin: synchronise, then demand the full low time before acting
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= 1'b1;
         rst_cnt_reg  <= '0;
         ext_rst_reg  <= 1'b0;
      end else if (clk_en) begin
         rst_meta_reg <= reset_pin_n;
         rst_sync_reg <= rst_meta_reg;
         if (rst_sync_reg) begin
            rst_cnt_reg <= '0;
            ext_rst_reg <= 1'b0;
         end else if (rst_cnt_reg == RST_CNT_W'(RST_MIN_CYC - 1)) begin
            ext_rst_reg <= 1'b1;
         end else begin
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
         end
      end
   end
   assign rst_int = sys_rst | ext_rst_reg;

   // Crystal clock buffer; half rate toggles on every second tick
   always_ff @(posedge clock) begin
      if (rst_int) begin
         crystal_clock_out <= 1'b0;
         xtal_phase_reg    <= 1'b0;
      end else if (clk_en && crystal_tick) begin
         xtal_phase_reg <= ~xtal_phase_reg;
         if (!crystal_half_sel || xtal_phase_reg)
            crystal_clock_out <= ~crystal_clock_out;
      end
   end

   // Serial pins and address strap pass two flops before use
   always_ff @(posedge clock) begin
      if (rst_int) begin
         ser_meta_reg <= 3'h3;
         ser_sync_reg <= 3'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else if (clk_en) begin
         ser_meta_reg <= {bus_address_select, serial_data_in, serial_clock};
         ser_sync_reg <= ser_meta_reg;
         scl_prev_reg <= ser_sync_reg[0];
         sda_prev_reg <= ser_sync_reg[1];
      end
   end

   assign ser_rise  = ser_sync_reg[0] & ~scl_prev_reg;
   assign ser_fall  = ~ser_sync_reg[0] & scl_prev_reg;
   assign ser_start = ser_sync_reg[0] & scl_prev_reg & sda_prev_reg & ~ser_sync_reg[1];
   assign ser_stop  = ser_sync_reg[0] & scl_prev_reg & ~sda_prev_reg & ser_sync_reg[1];
   assign my_addr   = ser_sync_reg[2] ? ADDR_PIN_HIGH : ADDR_PIN_LOW;

   // Address phase: acknowledge only our own address, ignore the rest
   always_ff @(posedge clock) begin
      if (rst_int) begin
         ser_state_reg <= SER_IDLE;
         ser_shift_reg <= 8'h00;
         ser_cnt_reg   <= 4'h0;
      end else if (clk_en) begin
         if (ser_start) begin
            ser_state_reg <= SER_ADDR;
            ser_cnt_reg   <= 4'h0;
         end else if (ser_stop) begin
            ser_state_reg <= SER_IDLE;
         end else begin
            case (ser_state_reg)
               SER_ADDR: begin
                  if (ser_rise && ser_cnt_reg != ADDR_BITS) begin
                     ser_shift_reg <= {ser_shift_reg[6:0], ser_sync_reg[1]};
                     ser_cnt_reg   <= ser_cnt_reg + 4'h1;
                  end else if (ser_fall && ser_cnt_reg == ADDR_BITS) begin
                     if (ser_shift_reg[7:1] == addr_byte(my_addr) >> 1)
                        ser_state_reg <= SER_ACK;
                     else
                        ser_state_reg <= SER_SKIP;
                  end
               end
               SER_ACK:  if (ser_fall) ser_state_reg <= SER_SKIP;
               SER_SKIP: ser_state_reg <= SER_SKIP;
               SER_IDLE: ser_state_reg <= SER_IDLE;
               default:  ser_state_reg <= SER_IDLE;
            endcase
         end
      end
   end

   // Open drain: drive only a low, release otherwise
   assign serial_data_out  = 1'b0;
   assign serial_data_oe_n = (ser_state_reg != SER_ACK);

   // Pixel launch; 48-bit mode pairs even and odd pixels
   assign launch = pix_valid & (~mode_48 | phase_reg);
   always_ff @(posedge clock) begin
      if (rst_int) begin
         phase_reg           <= 1'b0;
         {hold_r_reg, hold_g_reg, hold_b_reg} <= '0;
         red_primary_bus     <= '0;
         green_primary_bus   <= '0;
         blue_primary_bus    <= '0;
         red_secondary_bus   <= '0;
         green_secondary_bus <= '0;
         blue_secondary_bus  <= '0;
      end else if (clk_en && pix_valid) begin
         if (!mode_48) begin
            phase_reg         <= 1'b0;
            red_primary_bus   <= pix_red;
            green_primary_bus <= pix_green;
            blue_primary_bus  <= pix_blue;
         end else if (!phase_reg) begin
            phase_reg <= 1'b1;
            {hold_r_reg, hold_g_reg, hold_b_reg} <= {pix_red, pix_green, pix_blue};
         end else begin
            phase_reg           <= 1'b0;
            red_primary_bus     <= hold_r_reg;
            green_primary_bus   <= hold_g_reg;
            blue_primary_bus    <= hold_b_reg;
            red_secondary_bus   <= pix_red;
            green_secondary_bus <= pix_green;
            blue_secondary_bus  <= pix_blue;
         end
      end
   end

   // Buses float on request; pulldowns outside hold them low
   always_ff @(posedge clock) begin
      if (rst_int) bus_oe_n <= 1'b1;
      else if (clk_en) bus_oe_n <= bus_disable;
   end

   // Word clock falls at launch; rises the next cycle in 24-bit mode, mid-word in 48-bit mode
   always_ff @(posedge clock) begin
      if (rst_int) begin
         output_word_clock <= 1'b1;
      end else if (clk_en) begin
         if (launch) output_word_clock <= 1'b0;
         else if (!mode_48 || (pix_valid && !phase_reg)) output_word_clock <= 1'b1;
      end
   end
   assign output_word_clock_n = ~output_word_clock;

   // Line sync regenerated from leading edges; serrations during disruption dropped
   assign hs_lead  = pix_valid & pix_line_sync & ~hs_prev_reg;
   assign hs_trail = pix_valid & (hs_cnt_reg == 8'h01);
   always_ff @(posedge clock) begin
      if (rst_int) begin
         hs_prev_reg       <= 1'b0;
         hs_cnt_reg        <= 8'h00;
         aligned_line_sync <= 1'b0;
      end else if (clk_en) begin
         if (pix_valid) hs_prev_reg <= pix_line_sync;
         if (hs_lead && !disrupt && hs_cnt_reg == 8'h00) begin
            hs_cnt_reg        <= HS_WIDTH;
            aligned_line_sync <= 1'b1;
         end else if (pix_valid && hs_cnt_reg != 8'h00) begin
            hs_cnt_reg <= hs_cnt_reg - 8'h01;
            if (hs_trail) aligned_line_sync <= 1'b0;
         end
      end
   end

   // Synthetic frame sync: one line long, edges counted from line sync trail
   always_ff @(posedge clock) begin
      if (rst_int) begin
         fs_prev_reg          <= 1'b0;
         frame_pend_reg       <= 1'b0;
         vs_cnt_reg           <= 4'h0;
         synthetic_frame_sync <= 1'b0;
      end else if (clk_en) begin
         fs_prev_reg <= frame_sync_passthrough;
         // A new frame edge wins over the clear in the same cycle
         frame_pend_reg <= (frame_pend_reg & ~(hs_trail & vs_cnt_reg == 4'h0))
                         | (frame_sync_passthrough & ~fs_prev_reg);
         if (hs_trail && vs_cnt_reg == 4'h0 && (frame_pend_reg || synthetic_frame_sync)) begin
            vs_cnt_reg <= VS_DELAY;
         end else if (pix_valid && vs_cnt_reg != 4'h0) begin
            vs_cnt_reg <= vs_cnt_reg - 4'h1;
            if (vs_cnt_reg == 4'h1) synthetic_frame_sync <= ~synthetic_frame_sync;
         end
      end
   end

   // Buffered syncs; receiver takes frame timing from these, line starts from the aligned sync
   sync_passthrough u_pass (
      .clock                  (clock),
      .rst                    (rst_int),
      .clk_en                 (clk_en),
      .hsync_pin              (hsync_pin),
      .sog_pin                (sog_pin),
      .vsync_pin              (vsync_pin),
      .source_sel             (sync_source_sel),
      .line_sync_passthrough  (line_sync_passthrough),
      .frame_sync_passthrough (frame_sync_passthrough),
      .disrupt                (disrupt)
   );

   AST_RESET_PIN: assert property (@(posedge clock) disable iff (sys_rst)
      (clk_en && !rst_sync_reg && rst_cnt_reg == RST_CNT_W'(RST_MIN_CYC - 1)) |=> ext_rst_reg)
      else $error("reset pin held long enough but no reinit");

   AST_XTAL_HALF: assert property (@(posedge clock) disable iff (rst_int)
      (clk_en && crystal_tick && crystal_half_sel && !xtal_phase_reg)
      |=> $stable(crystal_clock_out))
      else $error("half-rate crystal clock toggled on the wrong tick");

   AST_ADDR_MATCH: assert property (@(posedge clock) disable iff (rst_int)
      $rose(ser_state_reg == SER_ACK) |-> $past(ser_shift_reg[7:1]) == $past(my_addr))
      else $error("acknowledged a foreign serial address");

   AST_OPEN_DRAIN: assert property (@(posedge clock) disable iff (rst_int)
      $fell(serial_data_oe_n) |-> $past(ser_fall))
      else $error("serial data pulled low away from a clock fall");

   AST_WORD_CLK_24: assert property (@(posedge clock) disable iff (rst_int)
      (clk_en && !mode_48 && !output_word_clock && !pix_valid) |=> output_word_clock)
      else $error("24-bit word clock did not rise after launch");

   AST_WORD_CLK_N: assert property (@(posedge clock) disable iff (rst_int)
      output_word_clock_n != output_word_clock)
      else $error("word clock pair not complementary");

   AST_NO_SERRATION: assert property (@(posedge clock) disable iff (rst_int)
      $rose(aligned_line_sync) |-> !$past(disrupt))
      else $error("aligned line sync started during disruption");

   AST_FRAME_DELAY: assert property (@(posedge clock) disable iff (rst_int)
      (clk_en && hs_trail && vs_cnt_reg == 4'h0 && frame_pend_reg) |=> vs_cnt_reg == VS_DELAY)
      else $error("frame sync delay not started at line sync trail");

   AST_PAIR_48: assert property (@(posedge clock) disable iff (rst_int)
      (clk_en && pix_valid && mode_48 && !phase_reg) |=> $stable(red_primary_bus) && phase_reg)
      else $error("48-bit mode launched on an even pixel");
endmodule : pixel_output_port

// file: sync_passthrough.sv
// Constants shared by the pixel output port, plus the buffered sync pass-through.
// Assumes all logic runs on one clock; sync pins arrive unsynchronised.
`timescale 1ns/10ps

package port_consts;
   localparam int          CLK_PERIOD_NS = 8;     // 125 MHz system clock
   localparam int          RST_MIN_NS    = 1000;  // Least low time of the reset pin
   localparam int          RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RST_CNT_W     = 8;
   localparam logic [6:0]  ADDR_PIN_LOW  = 7'h4C; // Serial address, select tied low
   localparam logic [6:0]  ADDR_PIN_HIGH = 7'h4D; // Serial address, select tied high
   localparam logic [3:0]  ADDR_BITS     = 4'h8;  // Address byte length with R/W bit
   localparam logic [3:0]  VS_DELAY      = 4'h8;  // Pixels from line sync trail to frame sync
   localparam logic [7:0]  HS_WIDTH      = 8'h10; // Regenerated line sync width, pixels
   localparam logic [7:0]  BROAD_MIN_CYC = 8'h40; // Sync pulse longer than this is disruption
   localparam logic [1:0]  SRC_HSYNC     = 2'h0;
   localparam logic [1:0]  SRC_SOG       = 2'h1;
   localparam logic [1:0]  SRC_CSYNC     = 2'h2;  // Composite sync on the line sync pin
   localparam int          PIX_W         = 8;

   // Write byte of a seven-bit serial address
   function automatic logic [7:0] addr_byte(input logic [6:0] a);
      addr_byte = {a, 1'b0};
   endfunction : addr_byte
endpackage : port_consts

module sync_passthrough
   import port_consts::*;
(
   input  wire logic       clock,                  // System clock
   input  wire logic       rst,                    // Synchronous reset, active high
   input  wire logic       clk_en,                 // Freezes state while low
   input  wire logic       hsync_pin,              // Separate or composite line sync pin
   input  wire logic       sog_pin,                // Sliced sync-on-green pin
   input  wire logic       vsync_pin,              // Separate frame sync pin
   input  wire logic [1:0] source_sel,             // Line sync source select
   output logic            line_sync_passthrough,  // Unaligned buffered line sync
   output logic            frame_sync_passthrough, // Buffered frame sync
   output logic            disrupt                 // Composite line pattern broken
);
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic       sel_line;
   logic       line_prev_reg;
   logic [7:0] width_reg;
   logic       disrupt_reg;
   logic       composite;

   // Two-stage synchronisers for the three sync pins
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg <= 3'h0;
         sync_reg <= 3'h0;
      end else if (clk_en) begin
         meta_reg <= {vsync_pin, sog_pin, hsync_pin};
         sync_reg <= meta_reg;
      end
   end

   assign composite = (source_sel == SRC_CSYNC);
   assign sel_line  = (source_sel == SRC_SOG) ? sync_reg[1] : sync_reg[0];
   assign disrupt   = disrupt_reg & composite;

   // Pass everything through, serrations and protection pulses included
   always_ff @(posedge clock) begin
      if (rst) begin
         line_sync_passthrough <= 1'b0;
      end else if (clk_en) begin
         line_sync_passthrough <= sel_line;
      end
   end

   // Broad pulses mark the frame interval of composite sync
   always_ff @(posedge clock) begin
      if (rst) begin
         width_reg     <= 8'h00;
         disrupt_reg   <= 1'b0;
         line_prev_reg <= 1'b0;
      end else if (clk_en) begin
         line_prev_reg <= sel_line;
         if (sel_line) begin
            if (width_reg != '1) width_reg <= width_reg + 8'h01;
            if (width_reg >= BROAD_MIN_CYC) disrupt_reg <= 1'b1;
         end else begin
            width_reg <= 8'h00;
            // A short pulse ends the disruption
            if (line_prev_reg && width_reg < BROAD_MIN_CYC) disrupt_reg <= 1'b0;
         end
      end
   end

   // Frame sync output: disruption for composite, the pin otherwise
   always_ff @(posedge clock) begin
      if (rst) begin
         frame_sync_passthrough <= 1'b0;
      end else if (clk_en) begin
         frame_sync_passthrough <= composite ? disrupt_reg : sync_reg[2];
      end
   end

   AST_PASS_LINE: assert property (@(posedge clock) disable iff (rst)
      (clk_en && source_sel == SRC_HSYNC)[*3] |=> line_sync_passthrough == $past(hsync_pin, 3))
      else $error("line sync pass-through does not follow the pin");

   AST_FRAME_DISRUPT: assert property (@(posedge clock) disable iff (rst)
      (clk_en && composite && disrupt_reg) |=> frame_sync_passthrough)
      else $error("frame sync not held during composite disruption");
endmodule : sync_passthrough

// file: pixel_receiver.sv
// Display-side pixel receiver model for the pixel output port.
// Assumes syncs settle on clock; counts line starts and frame starts.
`timescale 1ns/10ps

module pixel_receiver (
   input  wire logic clock,      // System clock
   input  wire logic line_sync,  // Aligned line sync
   input  wire logic frame_sync, // Buffered frame sync
   output int        lines,      // Line starts seen
   output int        frames      // Frame starts seen
);
   logic ls_d = 1'b0;
   logic fs_d = 1'b0;

   // Line starts from the aligned sync, frames from the buffered one
   always @(posedge clock) begin
      ls_d <= line_sync;
      fs_d <= frame_sync;
      if (line_sync && !ls_d) lines <= lines + 1;
      if (frame_sync && !fs_d) frames <= frames + 1;
   end
   initial begin
      lines = 0;
      frames = 0;
   end
endmodule : pixel_receiver

// file: pixel_output_port_tb.sv
// Self-checking bench for pixel_output_port with a pixel receiver model.
// Assumes 125 MHz clock; the bench plays the serial host and the sync sources.
`timescale 1ns/10ps

module pixel_output_port_tb;
   import port_consts::*;
   logic       clock = 0, sys_rst = 1, xt = 0, half = 0, sel = 0, scl = 1, sda_h = 1;
   logic       pv = 0, ls = 0, m48 = 0, dis = 0, hs = 0, sg = 0, vs = 0, ce = 1, rpn = 1;
   logic [1:0] src = 2'h0;
   logic [7:0] r, g, b, er, eb, rp, rs, gp, gs, bp, bs;
   logic       xo, sdo, sdoe, oe, wc, wcn, als, sfs, lsp, fsp, p;
   int         mismatches = 0, checked = 0, cycles = 0, seed = 32'hb6e2f2ac, n, lines, frames;
   wire        sda = sda_h & (sdoe | sdo); // Pulled-up open-drain wire

   pixel_output_port dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(ce),
      .reset_pin_n(rpn), .crystal_tick(xt), .crystal_half_sel(half), .crystal_clock_out(xo),
      .bus_address_select(sel), .serial_clock(scl), .serial_data_in(sda),
      .serial_data_out(sdo), .serial_data_oe_n(sdoe), .pix_red(r), .pix_green(g),
      .pix_blue(b), .pix_valid(pv), .pix_line_sync(ls), .mode_48(m48), .bus_disable(dis),
      .hsync_pin(hs), .sog_pin(sg), .vsync_pin(vs), .sync_source_sel(src),
      .red_primary_bus(rp), .red_secondary_bus(rs), .green_primary_bus(gp),
      .green_secondary_bus(gs), .blue_primary_bus(bp), .blue_secondary_bus(bs),
      .bus_oe_n(oe), .output_word_clock(wc), .output_word_clock_n(wcn),
      .aligned_line_sync(als), .synthetic_frame_sync(sfs), .line_sync_passthrough(lsp),
      .frame_sync_passthrough(fsp));
   pixel_receiver rx_u (.clock(clock), .line_sync(als), .frame_sync(fsp), .lines(lines),
      .frames(frames));

   // Write byte of the serial address picked by the strap level
   function automatic logic [7:0] addr_wr(input logic hi);
      return hi ? 8'h9A : 8'h98;
   endfunction : addr_wr

   always #4 clock = ~clock;

   task automatic close_out;
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // Hang guard, far above the roughly 1100 cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Inputs move 1 ns after the rising edge
   task automatic wt(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask : wt

   task automatic pix(input logic l);
      {r, g, b} = 24'($random(seed));
      ls = l;
      pv = 1;
      wt(1);
      pv = 0;
   endtask : pix

   // Slow serial bit, well above the pin synchronisers' delay
   task automatic sbit(input logic v);
      sda_h = v;
      wt(4);
      scl = 1;
      wt(8);
      scl = 0;
      wt(4);
   endtask : sbit

   initial begin
      wt(3);
      chk("bus_oe_n", 1, oe);
      chk("word_clock", 1, wc);
      sys_rst = 0;
      // Crystal buffer: half rate first, while its divider is fresh
      for (int h = 1; h >= 0; h--) begin
         half = h[0];
         n = 0;
         wt(4);
         repeat (4) begin
            p = xo;
            xt = 1;
            wt(1);
            xt = 0;
            wt(3);
            if (xo !== p) n++;
         end
         chk("xtal_toggles", h ? 2 : 4, 8'(n));
      end
      dis = 1;
      wt(2);
      chk("bus_oe_n", 1, oe);
      dis = 0;
      wt(2);
      chk("bus_oe_n", 0, oe);
      // 24-bit: one word per pixel, word clock low for one cycle
      repeat (6) begin
         pix(0);
         chk("red_pri", r, rp);
         chk("green_pri", g, gp);
         chk("blue_pri", b, bp);
         chk("word_clock", 0, wc);
         chk("word_clock_n", 1, wcn);
         wt(1);
         chk("word_clock", 1, wc);
         chk("word_clock_n", 0, wcn);
      end
      // Clock enable low: a pixel must not reach the buses
      er = r;
      ce = 0;
      pix(0);
      chk("red_pri_frozen", er, rp);
      ce = 1;
      m48 = 1;
      wt(3);
      // 48-bit pairs, back to back
      repeat (3) begin
         pix(0);
         er = r;
         eb = b;
         wt(1);
         pix(0);
         chk("red_pri", er, rp);
         chk("blue_pri", eb, bp);
         chk("red_sec", r, rs);
         chk("green_sec", g, gs);
         chk("blue_sec", b, bs);
         chk("word_clock", 0, wc);
         chk("word_clock_n", 1, wcn);
         wt(1);
      end
      m48 = 0;
      vs = 1;
      wt(4);
      chk("frame_pass", 1, fsp);
      pix(1);
      chk("aligned_sync", 1, als);
      for (int i = 1; i <= 24; i++) begin
         wt(1);
         pix(i < 4);
         if (i == 15) chk("aligned_sync", 1, als);
         if (i == 16) chk("aligned_sync", 0, als);
         if (i == 23) chk("synth_frame", 0, sfs);
         if (i == 24) chk("synth_frame", 1, sfs);
      end
      chk("rx_lines", 1, 8'(lines));
      chk("rx_frames", 1, 8'(frames));
      // Pass-through follows the chosen source after three edges
      for (int s = 0; s < 3; s++) begin
         src = 2'(s);
         hs = (s != 1);
         sg = (s == 1);
         wt(2);
         chk("line_pass_early", 0, lsp);
         wt(1);
         chk("line_pass", 1, lsp);
         hs = 0;
         sg = 0;
         wt(6);
      end
      // Composite: a broad pulse is disruption, line starts refused meanwhile
      hs = 1;
      wt(80);
      chk("frame_pass_cs", 1, fsp);
      pix(1);
      chk("aligned_sync_cs", 0, als);
      wt(1);
      pix(0);
      hs = 0;
      wt(4);
      hs = 1;
      wt(10);
      hs = 0;
      wt(6);
      chk("frame_pass_cs", 0, fsp);
      src = 2'h0;
      // Address byte with both strap levels; ACK only on a match
      for (int k = 0; k < 4; k++) begin
         sel = k[0];
         sda_h = 0;
         wt(8);
         scl = 0;
         wt(4);
         er = addr_wr(k[1]);
         for (int i = 7; i >= 0; i--) sbit(er[i]);
         chk("sda_oe_n", (k[0] == k[1]) ? 0 : 1, sdoe);
         chk("sda_out", 0, sdo);
         sbit(1);
         chk("sda_oe_n", 1, sdoe);
         sda_h = 0;
         wt(4);
         scl = 1;
         wt(4);
         sda_h = 1;
         wt(8);
      end
      // Reset pin: a full low time reinitialises, release restarts the port
      rpn = 0;
      wt(120);
      chk("bus_oe_n", 0, oe);
      wt(20);
      chk("bus_oe_n", 1, oe);
      chk("red_pri", 0, rp);
      rpn = 1;
      wt(4);
      chk("bus_oe_n", 0, oe);
      close_out();
   end
endmodule : pixel_output_port_tb
